// [rtl/tmr_map.svh]
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets on the slave port
// ----------------------------------------------------------------
`define TMR_OFS_CONFIG    4'h0
`define TMR_OFS_COUNT     4'h4
`define TMR_OFS_INTCTL    4'h8
`define TMR_OFS_MASK      4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMR_CFG_SRC       5
`define TMR_CFG_EDGE      4
`define TMR_CFG_PSA       3
`define TMR_CFG_RATE_HI   2
`define TMR_CFG_RATE_LO   0
`define TMR_INT_EN        5
`define TMR_INT_FLAG      2

// ----------------------------------------------------------------
// reset values, writable masks and timing counts
// ----------------------------------------------------------------
`define TMR_RST_CONFIG    8'h00
`define TMR_RST_COUNT     8'h00
`define TMR_CFG_WMASK     8'h3f
`define TMR_COUNT_MAX     8'hff
`define TMR_INHIBIT_INSTR 2'h2

`endif

// [rtl/tmr_pkg.sv]
package tmr_pkg;

    // four clock phases make one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } tmr_phase_type;

    typedef struct packed {
        tmr_phase_type phase;
        logic [7:0]    cfg;
        logic [7:0]    count;
        logic          flag;
        logic          en;
        logic [1:0]    inhibit;
        logic          sample;
        logic          edge_prev;
        logic          waitreq;
        logic [31:0]   rdata;
        logic          irq;
        logic          wdt_tick;
    } tmr_state_type;

endpackage

// [rtl/tmr_sync.sv]
`timescale 1ns/1ps

module tmr_sync (
    input  wire logic clk,    // block clock
    input  wire logic nrst,   // synchronous reset, active low
    input  wire logic din,    // asynchronous level
    output logic      dout    // level after two flops
);

    typedef struct packed {
        logic ff1;
        logic ff2;
    } tmr_sync_type;

    tmr_sync_type s_reg;
    tmr_sync_type s_next;

    always_comb begin
        s_next     = s_reg;
        s_next.ff1 = din;
        s_next.ff2 = s_reg.ff1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.ff2;

endmodule // tmr_sync

// [rtl/tmr_presc.sv]
`timescale 1ns/1ps

module tmr_presc #(
    parameter int WIDTH  = 8,
    parameter int RATE_W = 3
) (
    input  wire logic              clk,    // block clock
    input  wire logic              nrst,   // synchronous reset, active low
    input  wire logic              clear,  // clear the count
    input  wire logic              inc,    // one input event
    input  wire logic [RATE_W-1:0] rate,   // division select
    output logic      [WIDTH-1:0]  cnt,    // internal count, not software visible
    output logic                   level,  // divided output level
    output logic                   carry   // pulse when the division wraps
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } tmr_presc_type;

    tmr_presc_type p_reg;
    tmr_presc_type p_next;

    // ratio is two to the power of rate plus one
    function automatic logic [WIDTH-1:0] rate_mask(input logic [RATE_W-1:0] r);
        logic [WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < WIDTH; i++) begin
            m[i] = (i <= int'(r));
        end
        return m;
    endfunction

    always_comb begin
        p_next = p_reg;
        if (clear) begin
            p_next.cnt = '0;
        end else if (inc) begin
            p_next.cnt = WIDTH'(p_reg.cnt + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_reg <= '0;
        end else begin
            p_reg <= p_next;
        end
    end

    assign cnt   = p_reg.cnt;
    assign level = p_reg.cnt[rate];
    assign carry = inc && !clear && ((p_reg.cnt & rate_mask(rate)) == rate_mask(rate));

endmodule // tmr_presc

// [rtl/tmr_top.sv]
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "tmr_map.svh"

// Notes on behaviour
// [RULE1] timer mode, no prescaler: count every instruction
// [RULE2] count write holds increments two instruction cycles
// [RULE3] counter mode counts chosen edge of pin
// [RULE4] source bit one selects pin, zero instructions
// [RULE5] one prescaler, timer or watchdog, never both
// [RULE6] prescaler on timer: eight ratios 1:2..1:256
// [RULE7] assignment bit set bypasses prescaler, ratio 1:1
// [RULE8] prescaler hidden; count write clears it
// [RULE9] software order for moving prescaler to watchdog
// [RULE10] software order for moving prescaler back here
// [RULE11] wrap from ff to 00 sets flag
// [RULE12] flag stays set until software clears it
// [RULE13] interrupt needs flag and enable both set
// [RULE14] pin synchronised by sampling on Q2, Q4
// [RULE15] sleep freezes count and blocks wake
// [RULE16] rate field n divides by two^(n+1)
// [RULE17] everything resets to zero, prescaler too; the code resets waitrequest high
module tmr_top
    import tmr_pkg::*;
(
    input  wire logic        CLK,              // 40 MHz clock
    input  wire logic        NRST,             // synchronous reset, active low
    input  wire logic [3:0]  AVS_ADDRESS,      // byte address
    input  wire logic        AVS_READ,         // read request
    input  wire logic        AVS_WRITE,        // write request
    input  wire logic [31:0] AVS_WRITEDATA,    // write data
    input  wire logic [3:0]  AVS_BYTEENABLE,   // byte lanes
    output logic      [31:0] AVS_READDATA,     // read data
    output logic             AVS_WAITREQUEST,  // stall
    input  wire logic        EXT_COUNT_IN,     // external count pin
    input  wire logic        SLEEP,            // processor asleep
    input  wire logic        WDT_BASE_TICK,    // watchdog base pulse
    input  wire logic        WDT_CLEAR,        // watchdog clear pulse
    output logic             WDT_TICK,         // divided watchdog pulse
    output logic             IRQ               // timer interrupt level
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam tmr_state_type ST_RST = '{
        phase:     PH_Q1,
        cfg:       `TMR_RST_CONFIG,
        count:     `TMR_RST_COUNT,
        flag:      1'b0,
        en:        1'b0,
        inhibit:   2'h0,
        sample:    1'b0,
        edge_prev: 1'b0,
        waitreq:   1'b1,
        rdata:     32'h0000_0000,
        irq:       1'b0,
        wdt_tick:  1'b0
    };

    tmr_state_type st_reg;
    tmr_state_type st_next;

    logic       ext_sync;
    logic [7:0] presc_cnt;
    logic       presc_level;
    logic       presc_carry;
    logic       presc_inc;
    logic       presc_clear;

    logic       q2;
    logic       q4;
    logic       wr_take;
    logic       wr_cfg;
    logic       wr_cnt;
    logic       wr_int;
    logic       wr_mask;
    logic [7:0] wdata8;
    logic       src_ext;
    logic       prescaler_assignment;
    logic       adj;
    logic       ext_edge;
    logic       src_level;
    logic       raw_inc;
    logic       inc;
    logic       ovf;

    function automatic tmr_phase_type next_phase(input tmr_phase_type p);
        case (p)
            PH_Q1:   return PH_Q2;
            PH_Q2:   return PH_Q3;
            PH_Q3:   return PH_Q4;
            PH_Q4:   return PH_Q1;
            default: return PH_Q1;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [3:0] a, input tmr_state_type s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `TMR_OFS_CONFIG: v = s.cfg;
            `TMR_OFS_COUNT:  v = s.count;
            `TMR_OFS_INTCTL: begin
                v[`TMR_INT_EN]   = s.en;
                v[`TMR_INT_FLAG] = s.flag;
            end
            `TMR_OFS_MASK:   v[`TMR_INT_FLAG] = s.en;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // external pin and prescaler
    // ----------------------------------------------------------------
    tmr_sync u_sync (
        .clk  (CLK),
        .nrst (NRST),
        .din  (EXT_COUNT_IN),
        .dout (ext_sync)
    );

    tmr_presc #(
        .WIDTH  (8),
        .RATE_W (3)
    ) u_presc (
        .clk   (CLK),
        .nrst  (NRST),
        .clear (presc_clear),
        .inc   (presc_inc),
        .rate  (st_reg.cfg[`TMR_CFG_RATE_HI:`TMR_CFG_RATE_LO]), // RULE6 RULE16
        .cnt   (presc_cnt),
        .level (presc_level),
        .carry (presc_carry)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign q2      = (st_reg.phase == PH_Q2);
    assign q4      = (st_reg.phase == PH_Q4);
    // a write lands only on the edge where waitrequest is seen low
    assign wr_take = AVS_WRITE && !st_reg.waitreq && AVS_BYTEENABLE[0];
    assign wr_cfg  = wr_take && (AVS_ADDRESS == `TMR_OFS_CONFIG);
    assign wr_cnt  = wr_take && (AVS_ADDRESS == `TMR_OFS_COUNT);
    assign wr_int  = wr_take && (AVS_ADDRESS == `TMR_OFS_INTCTL);
    assign wr_mask = wr_take && (AVS_ADDRESS == `TMR_OFS_MASK);
    assign wdata8  = AVS_WRITEDATA[7:0];

    assign src_ext  = st_reg.cfg[`TMR_CFG_SRC];   // RULE4
    assign prescaler_assignment      = st_reg.cfg[`TMR_CFG_PSA];
    // invert for falling edge so one rising detector serves both
    assign adj      = ext_sync ^ st_reg.cfg[`TMR_CFG_EDGE]; // RULE3
    assign ext_edge = adj && !st_reg.edge_prev;

    // watchdog keeps its prescaler running through sleep
    assign presc_inc   = prescaler_assignment ? WDT_BASE_TICK
                             : (!SLEEP && (src_ext ? ext_edge : q4)); // RULE5
    assign presc_clear = prescaler_assignment ? WDT_CLEAR : wr_cnt; // RULE8

    // bypassed prescaler hands the pin level straight to sampling
    assign src_level = prescaler_assignment ? adj : presc_level; // RULE7

    // pin path only moves on Q2/Q4 samples, capping the input rate
    always_comb begin
        if (src_ext) begin
            raw_inc = (q2 || q4) && src_level && !st_reg.sample; // RULE14 RULE3
        end else begin
            raw_inc = q4 && (prescaler_assignment || presc_carry); // RULE1 RULE7 RULE6
        end
    end

    assign inc = raw_inc && !SLEEP && (st_reg.inhibit == 2'h0) && !wr_cnt; // RULE2 RULE15
    assign ovf = inc && (st_reg.count == `TMR_COUNT_MAX); // RULE11

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.phase = next_phase(st_reg.phase);

        // one wait cycle per request, then release
        st_next.waitreq = !((AVS_READ || AVS_WRITE) && st_reg.waitreq);
        if (AVS_READ && st_reg.waitreq) begin
            st_next.rdata = {24'h000000, reg_read(AVS_ADDRESS, st_reg)};
        end

        if (wr_cfg) begin
            st_next.cfg = wdata8 & `TMR_CFG_WMASK;
        end

        st_next.edge_prev = adj;
        if ((q2 || q4) && !SLEEP) begin
            st_next.sample = src_level; // RULE14
        end

        if (wr_cnt) begin
            st_next.inhibit = `TMR_INHIBIT_INSTR; // RULE2
        end else if (q4 && !SLEEP && (st_reg.inhibit != 2'h0)) begin
            st_next.inhibit = 2'(st_reg.inhibit - 2'h1); // RULE2
        end

        if (wr_cnt) begin
            st_next.count = wdata8;
        end else if (inc) begin
            st_next.count = 8'(st_reg.count + 8'h01); // RULE1
        end

        // set wins over a clear in the same cycle
        st_next.flag = (st_reg.flag && !(wr_int && wdata8[`TMR_INT_FLAG])) || ovf; // RULE12 RULE11

        if (wr_int) begin
            st_next.en = wdata8[`TMR_INT_EN];
        end else if (wr_mask) begin
            st_next.en = wdata8[`TMR_INT_FLAG];
        end

        st_next.irq      = st_next.flag && st_next.en; // RULE13
        st_next.wdt_tick = prescaler_assignment && presc_carry; // RULE5
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_reg <= ST_RST; // RULE17
        end else begin
            st_reg <= st_next;
        end
    end

    assign AVS_READDATA    = st_reg.rdata;
    assign AVS_WAITREQUEST = st_reg.waitreq;
    assign WDT_TICK        = st_reg.wdt_tick;
    assign IRQ             = st_reg.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence seq_cnt_write;
        wr_cnt;
    endsequence

    sequence seq_quiet4;
        (!wr_cnt)[*4];
    endsequence

    sequence seq_bypass_tick;
        !src_ext && prescaler_assignment && q4 && !SLEEP && (st_reg.inhibit == 2'h0) && !wr_cnt;
    endsequence

    AST_TIMER_INC: assert property ( // RULE1
        seq_bypass_tick |=> st_reg.count == 8'($past(st_reg.count) + 8'h01)
    ) else $error("count missed an instruction cycle");

    AST_WRITE_HOLD: assert property ( // RULE2
        seq_cnt_write ##1 seq_quiet4 |-> st_reg.count == $past(wdata8, 4)
    ) else $error("count moved inside the write hold-off");

    AST_OVF_SET: assert property ( // RULE11
        inc && (st_reg.count == 8'hff) |=> st_reg.flag && (st_reg.count == 8'h00)
    ) else $error("wrap did not set the overflow flag");

    AST_FLAG_STICKY: assert property ( // RULE12
        st_reg.flag && !(wr_int && wdata8[`TMR_INT_FLAG]) |=> st_reg.flag
    ) else $error("overflow flag dropped without software");

    AST_IRQ_LEVEL: assert property ( // RULE13
        IRQ == (st_reg.flag && st_reg.en)
    ) else $error("interrupt does not follow flag and enable");

    AST_SLEEP_FREEZE: assert property ( // RULE15
        SLEEP && !wr_cnt |=> $stable(st_reg.count)
    ) else $error("count moved during sleep");

    AST_PRESC_CLEAR: assert property ( // RULE8
        wr_cnt && !prescaler_assignment |=> presc_cnt == 8'h00
    ) else $error("count write left the prescaler running");

    AST_PIN_SAMPLE: assert property ( // RULE14
        src_ext && inc |-> (q2 || q4)
    ) else $error("pin count outside a sampling phase");

    sequence seq_flag_clear;
        wr_int && wdata8[`TMR_INT_FLAG] && !ovf;
    endsequence

    AST_FLAG_CLEAR: assert property ( // RULE12
        seq_flag_clear |=> !st_reg.flag
    ) else $error("software clear left the overflow flag set");

    AST_COUNT_LOAD: assert property ( // RULE2
        seq_cnt_write |=> st_reg.count == $past(wdata8)
    ) else $error("count write did not load the count");

    AST_CFG_WRITE: assert property ( // RULE4
        wr_cfg |=> st_reg.cfg == ($past(wdata8) & `TMR_CFG_WMASK)
    ) else $error("config write did not land");

    AST_WDT_QUIET: assert property ( // RULE5
        !prescaler_assignment |=> !WDT_TICK
    ) else $error("watchdog ticked while prescaler served the timer");

endmodule // tmr_top

// [sim/tmr_pin_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// far side: a source on the count pin
// ----------------------------------------
module tmr_pin_model
    import tmr_pkg::*;
#(
    parameter int HALF = 8
) (
    input  wire logic       clk,    // block clock
    input  wire logic       nrst,   // synchronous reset, active low
    input  wire logic       start,  // begin a burst
    input  wire logic [7:0] pulses, // pulses in the burst
    output logic            pin,    // count pin level
    output logic            busy    // burst running
);
    logic [8:0] edges_left;
    logic [7:0] dwell;

    assign busy = (edges_left != 9'h000);

    // each level held HALF clocks, far above two phases
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin <= 1'b0;
            edges_left <= 9'h000;
            dwell <= 8'h00;
        end else if (start && !busy) begin
            edges_left <= {pulses, 1'b0};
            dwell <= 8'h00;
        end else if (busy) begin
            if (dwell == 8'(HALF - 1)) begin
                pin <= ~pin;
                edges_left <= edges_left - 9'h001;
                dwell <= 8'h00;
            end else begin
                dwell <= dwell + 8'h01;
            end
        end
    end
endmodule // tmr_pin_model

// [sim/eight_bit_timer_counter_bench.sv]
`timescale 1ns/1ps
`include "tmr_map.svh"

module eight_bit_timer_counter_bench
    import tmr_pkg::*;
();
    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic [3:0]  AVS_ADDRESS = 4'h0;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h00000000;
    logic [3:0]  AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        EXT_COUNT_IN;
    logic        SLEEP = 1'b0;
    logic        WDT_BASE_TICK = 1'b0;
    logic        WDT_CLEAR = 1'b0;
    logic        WDT_TICK;
    logic        IRQ;
    logic        burst_go = 1'b0;
    logic [7:0]  burst_len = 8'h00;
    logic        burst_busy;
    int          mismatches = 0;
    int          comparisons = 0;
    int          seed = 32'he734;
    int          tick_total = 0;
    int          v;
    int          k;
    int          t0;
    int          want;

    tmr_top tmr_top_i (.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_COUNT_IN(EXT_COUNT_IN), .SLEEP(SLEEP),
        .WDT_BASE_TICK(WDT_BASE_TICK), .WDT_CLEAR(WDT_CLEAR), .WDT_TICK(WDT_TICK),
        .IRQ(IRQ));
    tmr_pin_model tmr_pin_model_i (.clk(CLK), .nrst(NRST), .start(burst_go),
        .pulses(burst_len), .pin(EXT_COUNT_IN), .busy(burst_busy));

    initial begin
        forever #12.5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        if (WDT_TICK === 1'b1)
            tick_total <= tick_total + 1;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until waitrequest is seen low; one idle edge after release
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        int n;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h000000, d};
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= w;
        AVS_READ <= ~w;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 64);
        r = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
        if (n >= 64) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 4'hf, r);
    endtask

    // a window is accepted where the pin or phase alignment is not fixed
    task automatic rd(input string name, input logic [3:0] a, input int lo, input int hi);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, 4'hf, r);
        chk(name, r, ($isunknown(r) || r < lo || r > hi) ? lo : r);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        rd("config", `TMR_OFS_CONFIG, 0, 0);
        rd("count", `TMR_OFS_COUNT, 0, 1);
        rd("intctl", `TMR_OFS_INTCTL, 0, 0);
        bus(1'b1, `TMR_OFS_CONFIG, 8'hff, 4'h0, v);
        rd("config lane off", `TMR_OFS_CONFIG, 0, 0);
        wr(`TMR_OFS_CONFIG, 8'hff);
        wr(4'h1, 8'hff);
        rd("config mask", `TMR_OFS_CONFIG, `TMR_CFG_WMASK, `TMR_CFG_WMASK);
        rd("unmapped", 4'h2, 0, 0);
        // bypass with a nonzero rate still counts 1:1
        wr(`TMR_OFS_CONFIG, 8'h0f);
        SLEEP <= 1'b1;
        v = $random(seed) & 32'h7f;
        wr(`TMR_OFS_COUNT, v[7:0]);
        idle(40);
        rd("sleep hold", `TMR_OFS_COUNT, v, v);
        SLEEP <= 1'b0;
        wr(`TMR_OFS_COUNT, v[7:0]);
        rd("inhibit", `TMR_OFS_COUNT, v, v);
        wr(`TMR_OFS_COUNT, v[7:0]);
        idle(100);
        rd("timer 1:1", `TMR_OFS_COUNT, v + 22, v + 25);
        for (int r = 0; r < 8; r++) begin
            wr(`TMR_OFS_CONFIG, r[7:0]);
            wr(`TMR_OFS_COUNT, 8'h00);
            idle(32 * (2 << r) + 8);
            rd("prescaled", `TMR_OFS_COUNT, 7, 9);
        end
        wr(`TMR_OFS_CONFIG, 8'h08);
        wr(`TMR_OFS_INTCTL, 8'h04);
        wr(`TMR_OFS_COUNT, 8'hfd);
        idle(40);
        rd("flag no enable", `TMR_OFS_INTCTL, 32'h04, 32'h04);
        chk("irq masked", IRQ, 32'h0);
        wr(`TMR_OFS_MASK, 8'h04);
        chk("irq raised", IRQ, 32'h1);
        idle(50);
        rd("flag sticky", `TMR_OFS_INTCTL, 32'h24, 32'h24);
        wr(`TMR_OFS_INTCTL, 8'h24);
        chk("irq cleared", IRQ, 32'h0);
        rd("mask alias", `TMR_OFS_MASK, 32'h04, 32'h04);
        // hand the prescaler to the watchdog in the safe order
        wr(`TMR_OFS_CONFIG, 8'h00);
        WDT_CLEAR <= 1'b1;
        @(posedge CLK);
        WDT_CLEAR <= 1'b0;
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_CONFIG, 8'h08);
        WDT_CLEAR <= 1'b1;
        @(posedge CLK);
        WDT_CLEAR <= 1'b0;
        wr(`TMR_OFS_CONFIG, 8'h09);
        t0 = tick_total;
        k = 0;
        repeat (160) begin
            v = $random(seed) & 32'h1;
            WDT_BASE_TICK <= v[0];
            k += v;
            @(posedge CLK);
        end
        WDT_BASE_TICK <= 1'b0;
        idle(4);
        chk("watchdog ticks", tick_total - t0, k / 4);
        WDT_CLEAR <= 1'b1;
        @(posedge CLK);
        WDT_CLEAR <= 1'b0;
        // rounds 0,1 give the prescaler back to the timer, 2,3 bypass it
        for (int e = 0; e < 4; e++) begin
            k = 32'h20 | (e[0] ? 32'h10 : 32'h00) | (e[1] ? 32'h08 : 32'h00);
            wr(`TMR_OFS_CONFIG, k[7:0]);
            idle(12);
            wr(`TMR_OFS_COUNT, 8'h00);
            idle(12);
            v = ($random(seed) & 32'h1f) + 1;
            // prescaler 1:2 level rises on every odd pin edge
            want = e[1] ? v : (v + 1) / 2;
            burst_len <= v[7:0];
            burst_go <= 1'b1;
            @(posedge CLK);
            burst_go <= 1'b0;
            k = 0;
            do begin
                @(posedge CLK);
                k++;
            end while (burst_busy === 1'b1 && k < 2000);
            if (k >= 2000) begin
                mismatches++;
                final_report();
            end
            idle(8);
            rd("pin count", `TMR_OFS_COUNT, want, want);
        end
        // reset again in mid-run with enable and config set
        NRST <= 1'b0;
        idle(2);
        NRST <= 1'b1;
        @(posedge CLK);
        rd("config after reset", `TMR_OFS_CONFIG, 0, 0);
        rd("intctl after reset", `TMR_OFS_INTCTL, 0, 0);
        final_report();
    end
endmodule // eight_bit_timer_counter_bench
